/* File: shared/pwpas_cfg.svh */
// register offsets, reset values and sub-addresses of the port configuration slice
// assumes one 8-bit port and an 8-bit indirect register interface
`ifndef PWPAS_CFG_SVH
`define PWPAS_CFG_SVH
`define PWPAS_SUB_WAKE 8'h05
`define PWPAS_SUB_PULLUP 8'h06
`define PWPAS_SUB_AFS_LOW 8'h07
`define PWPAS_SUB_AFS_HIGH 8'h08
`define PWPAS_RST_ZERO 8'h00
`define PWPAS_RST_AFS_SMALL 8'h04
`define PWPAS_ZERO_BIT 1'b0
`endif

/* File: shared/pwpas_pkg.sv */
// types shared by the port configuration slice
// assumes nothing of its surroundings
package pwpas_pkg;
	typedef enum logic [1:0] {PWPAS_FN_0, PWPAS_FN_1, PWPAS_FN_2, PWPAS_FN_3} pwpas_fn_t;
endpackage

/* File: verilog/pwpas_port_cfg.sv */
// per-pin wake, pull-up and alternate-function select slice of an 8-bit port
// assumes a cpu-side indirect access: address register write, then control register access
`timescale 1ns/1ps
`include "pwpas_cfg.svh"

module pwpas_port_cfg #(
	parameter bit SMALL_PORT = 1'b0
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic addr_wr,
	input wire logic [7:0] addr_wdata,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	output logic [7:0] ctrl_rdata,
	output logic [7:0] addr_rdata,
	input wire logic [7:0] altfunc_enable_bit,
	input wire logic [7:0] pin_in,
	input wire logic stop_mode,
	output logic stop_recover,
	output logic [7:0] pullup_on,
	output logic [7:0] altfunc_active,
	output pwpas_pkg::pwpas_fn_t altfunc_sel [8]
);
	logic [7:0] sub_addr_reg;
	logic [7:0] wake_source_enable_reg;
	logic [7:0] pullup_enable_reg;
	logic [7:0] altfunc_select_low_reg;
	logic [7:0] altfunc_select_high_reg;
	logic [7:0] pin_meta_reg;
	logic [7:0] pin_sync_reg;
	logic [7:0] stop_level_reg;
	logic stop_prev_reg;
	logic [7:0] afs_reset;
	logic [7:0] wake_source_enable_next;
	logic [7:0] pullup_enable_next;
	logic [7:0] altfunc_select_low_next;
	logic [7:0] altfunc_select_high_next;
	logic [7:0] ctrl_rdata_next;
	logic [7:0] stop_level_next;
	logic [7:0] pin_change;
	logic wr_wake;
	logic wr_pullup;
	logic wr_afs_low;
	logic wr_afs_high;
	logic stop_entry;

	assign afs_reset = SMALL_PORT ? `PWPAS_RST_AFS_SMALL : `PWPAS_RST_ZERO;

	function automatic logic sub_hit(input logic [7:0] sa, input logic [7:0] target);
		sub_hit = (sa == target);
	endfunction

	// sub-address latch for indirect access
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			sub_addr_reg <= `PWPAS_RST_ZERO;
		else if (addr_wr)
			sub_addr_reg <= addr_wdata;
	end

	// one write strobe per subregister; unmapped sub-addresses strobe nothing
	assign wr_wake = ctrl_wr && sub_hit(sub_addr_reg, `PWPAS_SUB_WAKE);
	assign wr_pullup = ctrl_wr && sub_hit(sub_addr_reg, `PWPAS_SUB_PULLUP);
	assign wr_afs_low = ctrl_wr && sub_hit(sub_addr_reg, `PWPAS_SUB_AFS_LOW);
	assign wr_afs_high = ctrl_wr && sub_hit(sub_addr_reg, `PWPAS_SUB_AFS_HIGH);

	// wake source enables
	always_comb
	begin
		wake_source_enable_next = wake_source_enable_reg;
		if (wr_wake)
			wake_source_enable_next = ctrl_wdata;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			wake_source_enable_reg <= `PWPAS_RST_ZERO;
		else
			wake_source_enable_reg <= wake_source_enable_next;
	end

	// pull-up enables
	always_comb
	begin
		pullup_enable_next = pullup_enable_reg;
		if (wr_pullup)
			pullup_enable_next = ctrl_wdata;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			pullup_enable_reg <= `PWPAS_RST_ZERO;
		else
			pullup_enable_reg <= pullup_enable_next;
	end

	// low select bits
	always_comb
	begin
		altfunc_select_low_next = altfunc_select_low_reg;
		if (wr_afs_low)
			altfunc_select_low_next = ctrl_wdata;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			altfunc_select_low_reg <= afs_reset;
		else
			altfunc_select_low_reg <= altfunc_select_low_next;
	end

	// high select bits
	always_comb
	begin
		altfunc_select_high_next = altfunc_select_high_reg;
		if (wr_afs_high)
			altfunc_select_high_next = ctrl_wdata;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			altfunc_select_high_reg <= afs_reset;
		else
			altfunc_select_high_reg <= altfunc_select_high_next;
	end

	// read mux; other sub-addresses read zero
	always_comb
	begin
		ctrl_rdata_next = `PWPAS_RST_ZERO;
		if (sub_hit(sub_addr_reg, `PWPAS_SUB_WAKE))
			ctrl_rdata_next = wake_source_enable_reg;
		else if (sub_hit(sub_addr_reg, `PWPAS_SUB_PULLUP))
			ctrl_rdata_next = pullup_enable_reg;
		else if (sub_hit(sub_addr_reg, `PWPAS_SUB_AFS_LOW))
			ctrl_rdata_next = altfunc_select_low_reg;
		else if (sub_hit(sub_addr_reg, `PWPAS_SUB_AFS_HIGH))
			ctrl_rdata_next = altfunc_select_high_reg;
	end

	// read data held in a flip-flop, one cycle behind the selected subregister
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ctrl_rdata <= `PWPAS_RST_ZERO;
		else
			ctrl_rdata <= ctrl_rdata_next;
	end

	assign addr_rdata = sub_addr_reg;

	// two-stage synchroniser for the pins
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pin_meta_reg <= `PWPAS_RST_ZERO;
			pin_sync_reg <= `PWPAS_RST_ZERO;
		end
		else
		begin
			pin_meta_reg <= pin_in;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// first cycle of stop mode: the entry level is taken then
	assign stop_entry = stop_mode && !stop_prev_reg;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			stop_prev_reg <= `PWPAS_ZERO_BIT;
		else
			stop_prev_reg <= stop_mode;
	end

	// level follows the pins outside stop mode, frozen from the entry edge on
	always_comb
	begin
		stop_level_next = stop_level_reg;
		if (!stop_mode || stop_entry)
			stop_level_next = pin_sync_reg;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			stop_level_reg <= `PWPAS_RST_ZERO;
		else
			stop_level_reg <= stop_level_next;
	end

	// enabled pins whose level left the entry level, in either direction
	assign pin_change = (pin_sync_reg ^ stop_level_reg) & wake_source_enable_reg;

	// combinational compare, so a pending change needs no further edge
	always_comb
	begin
		stop_recover = stop_mode && stop_prev_reg && (|pin_change);
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_pin
			assign altfunc_sel[g] = pwpas_pkg::pwpas_fn_t'({altfunc_select_high_reg[g],
				altfunc_select_low_reg[g]});
			assign altfunc_active[g] = altfunc_enable_bit[g];
			assign pullup_on[g] = pullup_enable_reg[g];
		end
	endgenerate
endmodule

/* File: sim/pwpas_port_cfg_asserts.sv */
// checker of the port configuration slice
// assumes binding to the slice top, one clock, sync reset
`timescale 1ns/1ps
module pwpas_chk(
	input logic clk_sys,
	input logic rst,
	input logic addr_wr,
	input logic [7:0] addr_wdata,
	input logic ctrl_wr,
	input logic [7:0] ctrl_wdata,
	input logic [7:0] ctrl_rdata,
	input logic [7:0] addr_rdata,
	input logic [7:0] altfunc_enable_bit,
	input logic [7:0] altfunc_active,
	input logic stop_mode,
	input logic stop_recover,
	input logic [7:0] pullup_on
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence pu_wr;
		ctrl_wr && addr_rdata == 8'h06;
	endsequence
	pull_wr_a: assert property (pu_wr |=> pullup_on == $past(ctrl_wdata))
		else $error("pullup write lost");
	pull_hold_a: assert property (!ctrl_wr |=> $stable(pullup_on))
		else $error("pullup changed");
	rd_back_a: assert property (addr_rdata == 8'h06 && $stable(addr_rdata) && $stable(pullup_on)
		|-> ctrl_rdata == pullup_on) else $error("pullup readback");
	unmapped_rd_a: assert property (!(addr_rdata inside {[8'h05:8'h08]}) && $stable(addr_rdata)
		|-> ctrl_rdata == 8'h00) else $error("unmapped read");
	addr_wr_a: assert property (addr_wr |=> addr_rdata == $past(addr_wdata))
		else $error("sub-address lost");
	idle_wake_a: assert property (!stop_mode |-> !stop_recover)
		else $error("wake outside stop");
	entry_wake_a: assert property ($rose(stop_mode) |-> !stop_recover)
		else $error("wake at entry");
	af_pass_a: assert property (altfunc_active == altfunc_enable_bit)
		else $error("enable not passed");
endmodule

/* File: sim/pwpas_pins.sv */
// pin model: driven, pulled up, or floating and toggling
`timescale 1ns/1ps
module pwpas_pins(
	input logic [7:0] pullup_on,
	input logic [7:0] drv_en,
	input logic [7:0] drv_val,
	output logic [7:0] pin_in
);
	logic [7:0] flt = 8'h5a;
	always #7 flt = ~flt;
	assign pin_in = drv_en & drv_val | ~drv_en & (pullup_on | flt);
endmodule

/* File: sim/tb_top.sv */
// bench of the port configuration slice
// assumes the pin model and the checker
`timescale 1ns/1ps
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin bad_count++; \
	$display("wrong value %s exp %h seen %h", n, e, v); end end
bind pwpas_port_cfg pwpas_chk i_chk(.clk_sys(clk_sys), .rst(rst), .addr_wr(addr_wr),
	.addr_wdata(addr_wdata), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
	.ctrl_rdata(ctrl_rdata), .addr_rdata(addr_rdata), .altfunc_enable_bit(altfunc_enable_bit),
	.altfunc_active(altfunc_active), .stop_mode(stop_mode), .stop_recover(stop_recover),
	.pullup_on(pullup_on));
module tb_top;
	logic clk_sys = 0, rst = 1, addr_wr = 0, ctrl_wr = 0, stop_mode = 0, stop_recover;
	logic [7:0] addr_wdata = 0, ctrl_wdata = 0, ctrl_rdata, addr_rdata, pin_in, pullup_on;
	logic [7:0] altfunc_active, altfunc_enable_bit = 8'h0f, drv_en = 8'hff, drv_val = 0;
	pwpas_pkg::pwpas_fn_t altfunc_sel [8];
	pwpas_pkg::pwpas_fn_t small_sel [8];
	int bad_count = 0, num_checks = 0, cyc = 0;
	// sub-address, write data, expected readback
	logic [23:0] rows [5] = '{24'h05a5a5, 24'h063c3c, 24'h078181, 24'h087e7e, 24'h0aff00};
	pwpas_port_cfg i_pwpas_port_cfg(.clk_sys(clk_sys), .rst(rst), .addr_wr(addr_wr),
		.addr_wdata(addr_wdata), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
		.ctrl_rdata(ctrl_rdata), .addr_rdata(addr_rdata),
		.altfunc_enable_bit(altfunc_enable_bit), .pin_in(pin_in), .stop_mode(stop_mode),
		.stop_recover(stop_recover), .pullup_on(pullup_on), .altfunc_active(altfunc_active),
		.altfunc_sel(altfunc_sel));
	// small-port variant, only its reset values are looked at
	pwpas_port_cfg #(.SMALL_PORT(1'b1)) i_pwpas_port_cfg_small(.clk_sys(clk_sys), .rst(rst),
		.addr_wr(1'b0), .addr_wdata(8'h00), .ctrl_wr(1'b0), .ctrl_wdata(8'h00),
		.ctrl_rdata(), .addr_rdata(), .altfunc_enable_bit(8'h00), .pin_in(8'h00),
		.stop_mode(1'b0), .stop_recover(), .pullup_on(), .altfunc_active(),
		.altfunc_sel(small_sel));
	pwpas_pins i_pwpas_pins(.pullup_on(pullup_on), .drv_en(drv_en), .drv_val(drv_val),
		.pin_in(pin_in));
	initial forever #5 clk_sys = ~clk_sys;
	task automatic acc(input logic [7:0] s, input logic [7:0] d);
		@(negedge clk_sys) addr_wr = 1; addr_wdata = s;
		@(negedge clk_sys) addr_wr = 0; ctrl_wr = 1; ctrl_wdata = d;
		@(negedge clk_sys) ctrl_wr = 0;
		@(negedge clk_sys);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			summarize;
		end
	end
	initial
	begin
		repeat (6) @(negedge clk_sys);
		rst = 0;
		`CHK("pullup reset", 8'h00, pullup_on)
		`CHK("select reset", pwpas_pkg::PWPAS_FN_0, altfunc_sel[2])
		`CHK("small select reset", pwpas_pkg::PWPAS_FN_3, small_sel[2])
		`CHK("small select other", pwpas_pkg::PWPAS_FN_0, small_sel[0])
		foreach (rows[i])
		begin
			acc(rows[i][23:16], rows[i][15:8]);
			`CHK("readback", rows[i][7:0], ctrl_rdata)
			`CHK("sub-address", rows[i][23:16], addr_rdata)
		end
		`CHK("pin select", pwpas_pkg::PWPAS_FN_1, altfunc_sel[0])
		`CHK("pin owner", 8'h0f, altfunc_active)
		`CHK("pin select two", pwpas_pkg::PWPAS_FN_2, altfunc_sel[1])
		altfunc_enable_bit = 8'hf0;
		@(negedge clk_sys);
		`CHK("pin owner swap", 8'hf0, altfunc_active)
		drv_en = 8'h00;
		#1 `CHK("pulled pins", 8'h3c, pin_in & 8'h3c)
		drv_en = 8'hff;
		acc(8'h05, 8'h01);
		stop_mode = 1;
		repeat (3) @(negedge clk_sys);
		drv_val = 8'h02;
		repeat (4) @(negedge clk_sys);
		`CHK("masked wake", 1'b0, stop_recover)
		drv_val = 8'h03;
		repeat (3) @(negedge clk_sys);
		`CHK("pin wake", 1'b1, stop_recover)
		stop_mode = 0;
		repeat (3) @(negedge clk_sys);
		`CHK("awake idle", 1'b0, stop_recover)
		stop_mode = 1;
		repeat (3) @(negedge clk_sys);
		`CHK("held level", 1'b0, stop_recover)
		drv_val = 8'h02;
		repeat (3) @(negedge clk_sys);
		`CHK("falling wake", 1'b1, stop_recover)
		rst = 1;
		repeat (2) @(negedge clk_sys);
		rst = 0;
		`CHK("pullup after reset", 8'h00, pullup_on)
		`CHK("sub-address after reset", 8'h00, addr_rdata)
		`CHK("select after reset", pwpas_pkg::PWPAS_FN_0, altfunc_sel[0])
		`CHK("wake after reset", 1'b0, stop_recover)
		summarize;
	end
endmodule
